// ===== logic/pifl_pkg.sv
// Constants for the peripheral interrupt flag and enable block
package pifl_pkg;
    localparam logic [7:0] FLAG3_OFF = 8'h00;
    localparam logic [7:0] EN1_OFF = 8'h04;
    localparam logic [7:0] EN2_OFF = 8'h08;
    localparam logic [7:0] CTRL_OFF = 8'h0c;
    localparam logic [7:0] PERIOD_OFF = 8'h10;
    localparam logic [7:0] STAT_OFF = 8'h14;
    localparam logic [7:0] MASK_OFF = 8'h18;
    localparam logic [7:0] FLAG3_BITS = 8'h10;
    localparam logic [7:0] EN1_BITS = 8'h7f;
    localparam logic [7:0] EN2_BITS = 8'h94;
    localparam logic [7:0] CTRL_BITS = 8'hf3;
    localparam logic [1:0] STAT_BITS = 2'h3;
    localparam int PWM_FLAG_POS = 4;
    localparam int PRIO_ON_POS = 0;
    localparam int GATE_POS = 1;
    localparam int POST_LSB = 4;
    localparam int POST_W = 4;
    localparam int EV_FLAG_POS = 0;
    localparam int EV_REQ_POS = 1;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    typedef enum logic [0:0] {BUS_IDLE, BUS_RDWAIT} pifl_bus_e;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
endpackage

// ===== logic/pifl_top.sv
// Peripheral interrupt flag and enable block with AHB-Lite slave
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pifl_top #(
    parameter int PERIOD_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] peri_flag_one,
    input wire logic [7:0] peri_flag_two,
    input wire logic [PERIOD_W-1:0] pwm_count,
    input wire logic pwm_timebase_en,
    output logic periph_req,
    output logic irq
);
    pifl_pkg::pifl_bus_e st_r, st_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic rdy_r, rdy_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] adr_r, adr_nxt;
    logic [7:0] fl3_r, fl3_nxt;
    logic [7:0] en1_r, en1_nxt;
    logic [7:0] en2_r, en2_nxt;
    logic [7:0] ctl_r, ctl_nxt;
    logic [PERIOD_W-1:0] per_r, per_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] msk_r, msk_nxt;
    logic [pifl_pkg::POST_W-1:0] pcnt_r, pcnt_nxt;
    logic mprev_r, mprev_nxt;
    logic req_r, req_nxt;
    logic irq_r, irq_nxt;
    logic match_now;
    logic match_evt;
    logic post_hit;
    logic any_req;
    logic acc;
    logic [pifl_pkg::POST_W-1:0] post_sel;

    assign acc = hsel && hready && (htrans == pifl_pkg::HTRANS_NONSEQ
        || htrans == pifl_pkg::HTRANS_SEQ);
    assign post_sel = ctl_r[pifl_pkg::POST_LSB +: pifl_pkg::POST_W];
    assign match_now = (pwm_count == per_r);
    assign match_evt = match_now && !mprev_r;
    assign post_hit = (pcnt_r == post_sel);
    assign any_req = (|(peri_flag_one & en1_r & pifl_pkg::EN1_BITS))
        || (|(peri_flag_two & en2_r & pifl_pkg::EN2_BITS))
        || (fl3_r[pifl_pkg::PWM_FLAG_POS] && pwm_timebase_en);

    // Bus phase tracking
    always_comb begin
        st_nxt = st_r;
        rdy_nxt = 1'b1;
        wr_nxt = 1'b0;
        adr_nxt = adr_r;
        hrdata_nxt = hrdata_r;
        case (st_r)
            pifl_pkg::BUS_IDLE: begin
                if (acc) begin
                    adr_nxt = haddr[7:0];
                    if (hwrite) begin
                        wr_nxt = 1'b1;
                    end else begin
                        st_nxt = pifl_pkg::BUS_RDWAIT;
                        rdy_nxt = 1'b0;
                    end
                end
            end
            pifl_pkg::BUS_RDWAIT: begin
                st_nxt = pifl_pkg::BUS_IDLE;
                hrdata_nxt = 32'h0000_0000;
                if (pifl_pkg::hit(adr_r, pifl_pkg::FLAG3_OFF)) begin
                    hrdata_nxt[7:0] = fl3_r & pifl_pkg::FLAG3_BITS;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::EN1_OFF)) begin
                    hrdata_nxt[7:0] = en1_r & pifl_pkg::EN1_BITS;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::EN2_OFF)) begin
                    hrdata_nxt[7:0] = en2_r & pifl_pkg::EN2_BITS;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::CTRL_OFF)) begin
                    hrdata_nxt[7:0] = ctl_r & pifl_pkg::CTRL_BITS;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::PERIOD_OFF)) begin
                    hrdata_nxt[PERIOD_W-1:0] = per_r;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::STAT_OFF)) begin
                    hrdata_nxt[1:0] = stat_r;
                end else if (pifl_pkg::hit(adr_r, pifl_pkg::MASK_OFF)) begin
                    hrdata_nxt[1:0] = msk_r;
                end
            end
            default: begin
                st_nxt = pifl_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= pifl_pkg::BUS_IDLE;
            rdy_r <= 1'b1;
            wr_r <= 1'b0;
            adr_r <= pifl_pkg::RST_REG;
            hrdata_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            rdy_r <= rdy_nxt;
            wr_r <= wr_nxt;
            adr_r <= adr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // Register file, flag logic and requests
    always_comb begin
        fl3_nxt = fl3_r;
        en1_nxt = en1_r;
        en2_nxt = en2_r;
        ctl_nxt = ctl_r;
        per_nxt = per_r;
        stat_nxt = stat_r;
        msk_nxt = msk_r;
        pcnt_nxt = pcnt_r;
        mprev_nxt = match_now;
        if (wr_r) begin
            if (pifl_pkg::hit(adr_r, pifl_pkg::FLAG3_OFF)) begin
                fl3_nxt = hwdata[7:0] & pifl_pkg::FLAG3_BITS;
            end
            if (pifl_pkg::hit(adr_r, pifl_pkg::EN1_OFF)) begin
                en1_nxt = hwdata[7:0] & pifl_pkg::EN1_BITS;
            end
            if (pifl_pkg::hit(adr_r, pifl_pkg::EN2_OFF)) begin
                en2_nxt = hwdata[7:0] & pifl_pkg::EN2_BITS;
            end
            if (pifl_pkg::hit(adr_r, pifl_pkg::CTRL_OFF)) begin
                ctl_nxt = hwdata[7:0] & pifl_pkg::CTRL_BITS;
            end
            if (pifl_pkg::hit(adr_r, pifl_pkg::PERIOD_OFF)) begin
                per_nxt = hwdata[PERIOD_W-1:0];
            end
            if (pifl_pkg::hit(adr_r, pifl_pkg::MASK_OFF)) begin
                msk_nxt = hwdata[1:0] & pifl_pkg::STAT_BITS;
            end
        end
        if (st_r == pifl_pkg::BUS_RDWAIT && pifl_pkg::hit(adr_r, pifl_pkg::STAT_OFF)) begin
            stat_nxt = 2'h0;
        end
        if (match_evt) begin
            if (post_hit) begin
                pcnt_nxt = '0;
                fl3_nxt[pifl_pkg::PWM_FLAG_POS] = 1'b1;
                stat_nxt[pifl_pkg::EV_FLAG_POS] = 1'b1;
            end else begin
                pcnt_nxt = pcnt_r + 1'b1;
            end
        end
        req_nxt = any_req && (ctl_r[pifl_pkg::PRIO_ON_POS]
            || ctl_r[pifl_pkg::GATE_POS]);
        if (req_nxt && !req_r) begin
            stat_nxt[pifl_pkg::EV_REQ_POS] = 1'b1;
        end
        irq_nxt = |(stat_r & msk_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fl3_r <= pifl_pkg::RST_REG;
            en1_r <= pifl_pkg::RST_REG;
            en2_r <= pifl_pkg::RST_REG;
            ctl_r <= pifl_pkg::RST_REG;
            per_r <= '0;
            stat_r <= 2'h0;
            msk_r <= 2'h0;
            pcnt_r <= '0;
            mprev_r <= 1'b1;
            req_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            fl3_r <= fl3_nxt;
            en1_r <= en1_nxt;
            en2_r <= en2_nxt;
            ctl_r <= ctl_nxt;
            per_r <= per_nxt;
            stat_r <= stat_nxt;
            msk_r <= msk_nxt;
            pcnt_r <= pcnt_nxt;
            mprev_r <= mprev_nxt;
            req_r <= req_nxt;
            irq_r <= irq_nxt;
        end
    end

    logic hresp_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = rdy_r;
    assign hresp = hresp_r;
    assign periph_req = req_r;
    assign irq = irq_r;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic wr_fl3;
    assign wr_fl3 = wr_r && pifl_pkg::hit(adr_r, pifl_pkg::FLAG3_OFF);

    property p_match_sets;
        match_evt && post_hit |=> fl3_r[4];
    endproperty
    a_match_sets: assert property (p_match_sets)
        else $error("period match did not set flag");

    property p_postscale;
        !fl3_r[4] && match_evt && !post_hit && !wr_fl3 |=> !fl3_r[4];
    endproperty
    a_postscale: assert property (p_postscale)
        else $error("flag set before postscale count");

    property p_sticky;
        fl3_r[4] && !wr_fl3 |=> fl3_r[4];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without software write");

    property p_fl3_read;
        st_r == pifl_pkg::BUS_RDWAIT && pifl_pkg::hit(adr_r, pifl_pkg::FLAG3_OFF)
            |=> (hrdata_r & 32'hffff_ffef) == 32'h0 && rdy_r;
    endproperty
    a_fl3_read: assert property (p_fl3_read)
        else $error("unused flag bits read nonzero");

    property p_gate_off;
        !ctl_r[0] && !ctl_r[1] |=> !req_r;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("request passed closed gate");

    property p_en1_write;
        wr_r && pifl_pkg::hit(adr_r, pifl_pkg::EN1_OFF)
            |=> en1_r == (($past(hwdata[7:0])) & 8'h7f);
    endproperty
    a_en1_write: assert property (p_en1_write)
        else $error("enable one write wrong");

    property p_en2_read;
        st_r == pifl_pkg::BUS_RDWAIT && pifl_pkg::hit(adr_r, pifl_pkg::EN2_OFF)
            |=> (hrdata_r & 32'hffff_ff6b) == 32'h0;
    endproperty
    a_en2_read: assert property (p_en2_read)
        else $error("enable two unused bits nonzero");

    property p_en2_bits;
        wr_r && pifl_pkg::hit(adr_r, pifl_pkg::EN2_OFF) && hwdata[7]
            |=> en2_r[7] ##0 (en2_r & 8'h6b) == 8'h0;
    endproperty
    a_en2_bits: assert property (p_en2_bits)
        else $error("enable two write wrong");

    property p_req_rise;
        (|(peri_flag_one & en1_r & 8'h7f)) && ctl_r[1] |=> req_r;
    endproperty
    a_req_rise: assert property (p_req_rise)
        else $error("enabled flag raised no request");

    property p_prio_on;
        any_req && ctl_r[0] |=> req_r;
    endproperty
    a_prio_on: assert property (p_prio_on)
        else $error("priority mode blocked request");

    property p_gate_one;
        (|(peri_flag_two & en2_r & 8'h94)) && ctl_r[1] |=> req_r;
    endproperty
    a_gate_one: assert property (p_gate_one)
        else $error("enable two source ignored");

    property p_rd_wait;
        acc && !hwrite |=> !rdy_r ##1 rdy_r;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");

    property p_irq_on;
        (stat_r & msk_r) != 2'h0 |=> irq_r;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("unmasked status raised no interrupt");

    property p_irq_off;
        (stat_r & msk_r) == 2'h0 |=> !irq_r;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt without unmasked status");

    property p_stat_flag;
        match_evt && post_hit |=> stat_r[0];
    endproperty
    a_stat_flag: assert property (p_stat_flag)
        else $error("flag event not recorded in status");

    property p_stat_req;
        req_nxt && !req_r |=> stat_r[1];
    endproperty
    a_stat_req: assert property (p_stat_req)
        else $error("request rise not recorded in status");

    property p_stat_clear;
        st_r == pifl_pkg::BUS_RDWAIT && pifl_pkg::hit(adr_r, pifl_pkg::STAT_OFF)
            && !match_evt && !(req_nxt && !req_r) |=> stat_r == 2'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status read did not clear");

    property p_fl3_unused;
        wr_fl3 |=> (fl3_r & 8'hef) == 8'h0;
    endproperty
    a_fl3_unused: assert property (p_fl3_unused)
        else $error("unused flag bits took a write");

    property p_flag_clear;
        wr_fl3 && !hwdata[4] && !(match_evt && post_hit) |=> !fl3_r[4];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("software clear of flag lost");

    property p_pwm_req;
        fl3_r[4] && pwm_timebase_en && ctl_r[1] |=> req_r;
    endproperty
    a_pwm_req: assert property (p_pwm_req)
        else $error("time-base flag raised no request");

    property p_req_off;
        !any_req |=> !req_r;
    endproperty
    a_req_off: assert property (p_req_off)
        else $error("request without enabled flag");

endmodule // pifl_top
`default_nettype wire

// ===== tb/pifl_peri_model.sv
// Peripheral model driving flag levels and the PWM time base
`timescale 1ns/1ps
`default_nettype none
module pifl_peri_model #(
    parameter int PERIOD_W = 12
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [7:0] set_one,
    input wire logic [7:0] set_two,
    input wire logic base_en,
    input wire logic [PERIOD_W-1:0] wrap,
    output logic [7:0] peri_flag_one,
    output logic [7:0] peri_flag_two,
    output logic [PERIOD_W-1:0] pwm_count,
    output logic pwm_timebase_en
);
    // Counter starts at one so no match is seen out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peri_flag_one <= 8'h00;
            peri_flag_two <= 8'h00;
            pwm_count <= {{(PERIOD_W-1){1'b0}}, 1'b1};
            pwm_timebase_en <= 1'b0;
        end else begin
            peri_flag_one <= set_one;
            peri_flag_two <= set_two;
            pwm_timebase_en <= base_en;
            if (run) begin
                pwm_count <= (pwm_count == wrap) ? '0 : pwm_count + 1'b1;
            end
        end
    end
endmodule // pifl_peri_model
`default_nettype wire

// ===== tb/tb.sv
// Testbench for the peripheral interrupt flag and enable block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int PW = 12;
    logic hclk, hresetn, hsel, hwrite, run, base_en;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0] htrans;
    logic [7:0] set_one, set_two, peri_flag_one, peri_flag_two;
    logic [PW-1:0] pwm_count;
    logic hreadyout, hresp, periph_req, irq, pwm_timebase_en;
    int num_errors, n_checks;
    pifl_top #(.PERIOD_W(PW)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .peri_flag_one(peri_flag_one), .peri_flag_two(peri_flag_two),
        .pwm_count(pwm_count), .pwm_timebase_en(pwm_timebase_en),
        .periph_req(periph_req), .irq(irq));
    pifl_peri_model #(.PERIOD_W(PW)) peri (.hclk(hclk), .hresetn(hresetn), .run(run),
        .set_one(set_one), .set_two(set_two), .base_en(base_en), .wrap(12'h003),
        .peri_flag_one(peri_flag_one), .peri_flag_two(peri_flag_two),
        .pwm_count(pwm_count), .pwm_timebase_en(pwm_timebase_en));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        for (int i = 0; i < 20; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) begin
                rd_q = hrdata;
                chk({31'h0, hresp}, 32'h0);
                return;
            end
        end
        num_errors++;
        $display("[FAIL] %0t bus wait ran out", $time);
        finish_test();
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= pifl_pkg::HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask
    task automatic req_chk(input logic exp);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        chk({31'h0, periph_req}, {31'h0, exp});
    endtask
    task automatic pulse_run();
        @(posedge hclk);
        run <= 1'b1;
        repeat (4) @(posedge hclk);
        run <= 1'b0;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 7; a++) rd_chk(8'(a * 4), 32'h0);
        chk({30'h0, periph_req, irq}, 32'h0);
    endtask
    task automatic t_regs();
        xfer(1'b1, pifl_pkg::EN1_OFF, 32'hffffffff);
        rd_chk(pifl_pkg::EN1_OFF, 32'h7f);
        xfer(1'b1, pifl_pkg::EN2_OFF, 32'hffffffff);
        rd_chk(pifl_pkg::EN2_OFF, 32'h94);
        xfer(1'b1, pifl_pkg::FLAG3_OFF, 32'hff);
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h10);
        xfer(1'b1, pifl_pkg::FLAG3_OFF, 32'h0);
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h0);
        rd_chk(8'h40, 32'h0);
        xfer(1'b1, pifl_pkg::EN1_OFF, 32'h0);
        xfer(1'b1, pifl_pkg::EN2_OFF, 32'h0);
    endtask
    task automatic t_gate();
        int k[3] = '{7, 4, 2};
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h2);
        for (int i = 0; i < 7; i++) begin
            set_one <= 8'h01 << i;
            xfer(1'b1, pifl_pkg::EN1_OFF, 32'h1 << i);
            req_chk(1'b1);
            xfer(1'b1, pifl_pkg::EN1_OFF, 32'h1 << ((i + 1) % 7));
            req_chk(1'b0);
        end
        set_one <= 8'h00;
        for (int j = 0; j < 3; j++) begin
            set_two <= 8'h01 << k[j];
            xfer(1'b1, pifl_pkg::EN2_OFF, 32'h1 << k[j]);
            req_chk(1'b1);
            xfer(1'b1, pifl_pkg::EN2_OFF, 32'h94 & ~(32'h1 << k[j]));
            req_chk(1'b0);
        end
        xfer(1'b1, pifl_pkg::EN2_OFF, 32'h94);
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h0);
        req_chk(1'b0);
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h1);
        req_chk(1'b1);
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h0);
        set_two <= 8'h00;
        xfer(1'b1, pifl_pkg::EN2_OFF, 32'h0);
    endtask
    task automatic t_pwm();
        xfer(1'b1, pifl_pkg::PERIOD_OFF, 32'h3);
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h10);
        xfer(1'b1, pifl_pkg::MASK_OFF, 32'h0);
        xfer(1'b0, pifl_pkg::STAT_OFF, 32'h0);
        pulse_run();
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h0);
        pulse_run();
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h10);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, pifl_pkg::MASK_OFF, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(pifl_pkg::STAT_OFF, 32'h1);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        repeat (20) @(posedge hclk);
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h10);
        xfer(1'b1, pifl_pkg::CTRL_OFF, 32'h12);
        req_chk(1'b0);
        base_en <= 1'b1;
        req_chk(1'b1);
        xfer(1'b1, pifl_pkg::FLAG3_OFF, 32'h0);
        req_chk(1'b0);
        rd_chk(pifl_pkg::FLAG3_OFF, 32'h0);
    endtask
    task automatic t_rerun();
        xfer(1'b1, pifl_pkg::EN1_OFF, 32'h7f);
        xfer(1'b1, pifl_pkg::PERIOD_OFF, 32'h3);
        xfer(1'b1, pifl_pkg::MASK_OFF, 32'h3);
        repeat (2) @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        base_en <= 1'b0;
        t_reset();
    endtask
    initial begin
        num_errors = 0;
        n_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        run = 1'b0;
        base_en = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        set_one = 8'h00;
        set_two = 8'h00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_regs();
        t_gate();
        t_pwm();
        t_rerun();
        finish_test();
    end
endmodule // tb
`default_nettype wire
